// ===== logic/storm_led_pkg.sv
/*
 * shared constants and types for the storm threshold / led global control bank.
 * assumes a single 125 MHz core clock and an 8-bit register port at byte offsets.
 */
package storm_led_pkg;

	localparam int NUM_PORTS = 5;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int THR_W = 11;
	localparam int THR_HIGH_W = 3;
	localparam int THR_LOW_W = 8;

	// register offsets
	localparam logic [7:0] ADDR_STORM_THRESHOLD_HIGH = 8'h06;
	localparam logic [7:0] ADDR_STORM_THRESHOLD_LOW = 8'h07;
	localparam logic [7:0] ADDR_FACTORY_TEST_A = 8'h08;
	localparam logic [7:0] ADDR_FACTORY_TEST_B = 8'h09;
	localparam logic [7:0] ADDR_FACTORY_TEST_C = 8'h0A;
	localparam logic [7:0] ADDR_POWER_SAVE_LED_CONTROL = 8'h0B;

	// reset values
	localparam logic [2:0] RST_STORM_THRESHOLD_HIGH = 3'h0;
	localparam logic [7:0] RST_STORM_THRESHOLD_LOW = 8'h4A;
	localparam logic [7:0] RST_FACTORY_TEST_A = 8'h24;
	localparam logic [7:0] RST_FACTORY_TEST_B = 8'h28;
	localparam logic [7:0] RST_FACTORY_TEST_C = 8'h24;
	localparam logic [3:0] RST_POWER_SAVE_LED_LOW = 4'h0;
	localparam logic [7:0] READ_ZERO = 8'h00;

	// power_save_led_control fields
	localparam int PS_DISABLE_BIT = 3;
	localparam int FACTORY_SETTING_BIT = 2;
	localparam int LED_SCHEME_BIT = 1;
	localparam int CTRL_RESERVED_BIT = 0;
	localparam int CTRL_USED_W = 4;

	// led levels, active low
	localparam logic LED_ON = 1'b0;
	localparam logic LED_OFF = 1'b1;
	localparam logic [2:0] LED_ALL_OFF = 3'h7;

	// measurement window timing
	localparam int CLK_MHZ = 125;
	localparam int WINDOW_FAST_MS = 50;
	localparam int WINDOW_SLOW_MS = 500;
	localparam int CYCLES_PER_MS = CLK_MHZ * 1000;
	localparam int WINDOW_FAST_CYCLES = WINDOW_FAST_MS * CYCLES_PER_MS;
	localparam int WINDOW_SLOW_CYCLES = WINDOW_SLOW_MS * CYCLES_PER_MS;
	localparam int WIN_CNT_W = 26;

	typedef enum logic {
		LED_SCHEME_0 = 1'b0,
		LED_SCHEME_1 = 1'b1
	} led_scheme_e;

	typedef enum logic {
		STRAP_PENDING = 1'b0,
		STRAP_DONE = 1'b1
	} strap_state_e;

	typedef struct packed {
		logic link_up;
		logic speed_100;
		logic full_duplex;
		logic activity;
		logic collision;
	} port_status_s;

endpackage

// ===== logic/storm_port_meter.sv
/*
 * per-port broadcast storm meter: repeating window timer and 64-byte block counter.
 * assumes one i_block pulse per 64-byte block of incoming broadcast data.
 */
`timescale 1ns/100ps
module storm_port_meter #(
	parameter int WIN_FAST_CYCLES = storm_led_pkg::WINDOW_FAST_CYCLES,
	parameter int WIN_SLOW_CYCLES = storm_led_pkg::WINDOW_SLOW_CYCLES
) (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_enable,
	input wire logic i_speed_100,
	input wire logic i_block,
	input wire logic [storm_led_pkg::THR_W-1:0] i_threshold,
	output logic o_drop,
	output logic o_window_end,
	output logic [storm_led_pkg::THR_W-1:0] o_block_count
);
	localparam logic [storm_led_pkg::WIN_CNT_W-1:0] FAST_LAST =
		storm_led_pkg::WIN_CNT_W'(WIN_FAST_CYCLES - 1);
	localparam logic [storm_led_pkg::WIN_CNT_W-1:0] SLOW_LAST =
		storm_led_pkg::WIN_CNT_W'(WIN_SLOW_CYCLES - 1);

	logic [storm_led_pkg::WIN_CNT_W-1:0] win_cnt_reg;
	logic [storm_led_pkg::WIN_CNT_W-1:0] win_cnt_next;
	logic [storm_led_pkg::THR_W-1:0] count_reg;
	logic [storm_led_pkg::THR_W-1:0] count_next;
	wire [storm_led_pkg::WIN_CNT_W-1:0] win_last = i_speed_100 ? FAST_LAST : SLOW_LAST;
	// >= so that a speed rise from slow to fast mid-window ends the window at once
	wire boundary = (win_cnt_reg >= win_last);
	wire at_limit = (count_reg >= i_threshold);
	wire take_block = i_block & ~at_limit;

	assign win_cnt_next = boundary ? '0 : win_cnt_reg + 1'b1;
	// a block arriving on the boundary cycle starts the new window
	assign count_next = boundary ? {{(storm_led_pkg::THR_W-1){1'b0}}, i_block}
		: (take_block ? count_reg + 1'b1 : count_reg);
	assign o_drop = i_enable & at_limit;
	assign o_window_end = boundary;
	assign o_block_count = count_reg;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			win_cnt_reg <= '0;
			count_reg <= '0;
		end else begin
			win_cnt_reg <= win_cnt_next;
			count_reg <= count_next;
		end
	end
endmodule

// ===== logic/storm_rate_led_global_control.sv
/*
 * global control bank of a five-port switch: storm threshold, factory test bytes,
 * phy power save and led scheme, plus per-port storm meters and led drivers.
 * assumes an 8-bit register port with one-cycle strobes, read data one cycle later,
 * and per-port link status, activity and broadcast block pulses from the switch core.
 */
// Added by the designer: the plain strobed port.
//
// Summary of operation
// - threshold is 11 bits from two registers
// - threshold resets to 000 high, 0x4A low
// - power save on when bit is 0
// - scheme 0 led codes per speed and duplex
// - scheme 1 led codes per speed and duplex
// - leds are active low
// - led output functions depend on scheme
// - led scheme reset value from strap pin
`timescale 1ns/100ps
module storm_rate_led_global_control #(
	parameter int WINDOW_FAST_CYCLES = storm_led_pkg::WINDOW_FAST_CYCLES,
	parameter int WINDOW_SLOW_CYCLES = storm_led_pkg::WINDOW_SLOW_CYCLES
) (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic [storm_led_pkg::ADDR_W-1:0] i_reg_addr,
	input wire logic [storm_led_pkg::DATA_W-1:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [storm_led_pkg::DATA_W-1:0] o_reg_rdata,
	input wire logic i_led_scheme_strap_pin,
	input wire storm_led_pkg::port_status_s [storm_led_pkg::NUM_PORTS-1:0] i_port_status,
	input wire logic [storm_led_pkg::NUM_PORTS-1:0] i_storm_enable,
	input wire logic [storm_led_pkg::NUM_PORTS-1:0] i_bcast_block,
	output logic [storm_led_pkg::NUM_PORTS-1:0] o_bcast_drop,
	output logic [storm_led_pkg::NUM_PORTS-1:0] o_window_end,
	output logic o_phy_power_save_en,
	output logic [storm_led_pkg::NUM_PORTS-1:0] o_port_indicator_two,
	output logic [storm_led_pkg::NUM_PORTS-1:0] o_port_indicator_one,
	output logic [storm_led_pkg::NUM_PORTS-1:0] o_port_indicator_zero
);
	// led code for one port, bits {two, one, zero}; activity blanks the link led
	function automatic logic [2:0] led_code(input logic scheme, input storm_led_pkg::port_status_s st);
		logic two;
		logic one;
		logic zero;
		two = storm_led_pkg::LED_OFF;
		one = storm_led_pkg::LED_OFF;
		zero = storm_led_pkg::LED_OFF;
		if (st.link_up) begin
			case (scheme)
				storm_led_pkg::LED_SCHEME_0: begin
					two = st.activity ? storm_led_pkg::LED_OFF : storm_led_pkg::LED_ON;
					one = (st.full_duplex | st.collision) ? storm_led_pkg::LED_ON : storm_led_pkg::LED_OFF;
					zero = st.speed_100 ? storm_led_pkg::LED_ON : storm_led_pkg::LED_OFF;
				end
				storm_led_pkg::LED_SCHEME_1: begin
					two = (st.speed_100 & ~st.activity) ? storm_led_pkg::LED_ON : storm_led_pkg::LED_OFF;
					one = (~st.speed_100 & ~st.activity) ? storm_led_pkg::LED_ON : storm_led_pkg::LED_OFF;
					zero = st.full_duplex ? storm_led_pkg::LED_ON : storm_led_pkg::LED_OFF;
				end
				default: begin
					two = storm_led_pkg::LED_OFF;
				end
			endcase
		end
		return {two, one, zero};
	endfunction

	logic [storm_led_pkg::THR_HIGH_W-1:0] thr_high_reg;
	logic [storm_led_pkg::THR_LOW_W-1:0] thr_low_reg;
	logic [storm_led_pkg::DATA_W-1:0] factory_a_reg;
	logic [storm_led_pkg::DATA_W-1:0] factory_b_reg;
	logic [storm_led_pkg::DATA_W-1:0] factory_c_reg;
	logic ps_disable_reg;
	logic factory_setting_reg;
	logic ctrl_reserved_reg;
	logic led_scheme_reg;
	storm_led_pkg::strap_state_e strap_state_reg;
	logic [storm_led_pkg::DATA_W-1:0] rdata_reg;
	logic [storm_led_pkg::NUM_PORTS-1:0] ind_two_reg;
	logic [storm_led_pkg::NUM_PORTS-1:0] ind_one_reg;
	logic [storm_led_pkg::NUM_PORTS-1:0] ind_zero_reg;

	// address decode
	wire hit_thr_high = (i_reg_addr == storm_led_pkg::ADDR_STORM_THRESHOLD_HIGH);
	wire hit_thr_low = (i_reg_addr == storm_led_pkg::ADDR_STORM_THRESHOLD_LOW);
	wire hit_fact_a = (i_reg_addr == storm_led_pkg::ADDR_FACTORY_TEST_A);
	wire hit_fact_b = (i_reg_addr == storm_led_pkg::ADDR_FACTORY_TEST_B);
	wire hit_fact_c = (i_reg_addr == storm_led_pkg::ADDR_FACTORY_TEST_C);
	wire hit_ctrl = (i_reg_addr == storm_led_pkg::ADDR_POWER_SAVE_LED_CONTROL);

	wire [storm_led_pkg::THR_W-1:0] threshold = {thr_high_reg, thr_low_reg};
	wire [storm_led_pkg::DATA_W-1:0] thr_high_view =
		{{(storm_led_pkg::DATA_W-storm_led_pkg::THR_HIGH_W){1'b0}}, thr_high_reg};
	// upper nibble of the control register is reserved and reads zero
	wire [storm_led_pkg::DATA_W-1:0] ctrl_view =
		{{(storm_led_pkg::DATA_W-storm_led_pkg::CTRL_USED_W){1'b0}},
		ps_disable_reg, factory_setting_reg, led_scheme_reg, ctrl_reserved_reg};
	wire [storm_led_pkg::DATA_W-1:0] rd_value =
		hit_thr_high ? thr_high_view :
		hit_thr_low ? thr_low_reg :
		hit_fact_a ? factory_a_reg :
		hit_fact_b ? factory_b_reg :
		hit_fact_c ? factory_c_reg :
		hit_ctrl ? ctrl_view : storm_led_pkg::READ_ZERO;
	wire [storm_led_pkg::DATA_W-1:0] rdata_next = i_reg_rd ? rd_value : storm_led_pkg::READ_ZERO;

	wire wr_ctrl = i_reg_wr & hit_ctrl;
	wire strap_pending = (strap_state_reg == storm_led_pkg::STRAP_PENDING);
	// strap wins over a write in the first cycle after reset release
	wire led_scheme_next = strap_pending ? i_led_scheme_strap_pin
		: (wr_ctrl ? i_reg_wdata[storm_led_pkg::LED_SCHEME_BIT] : led_scheme_reg);

	assign o_reg_rdata = rdata_reg;
	assign o_phy_power_save_en = ~ps_disable_reg;
	assign o_port_indicator_two = ind_two_reg;
	assign o_port_indicator_one = ind_one_reg;
	assign o_port_indicator_zero = ind_zero_reg;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			thr_high_reg <= storm_led_pkg::RST_STORM_THRESHOLD_HIGH;
			thr_low_reg <= storm_led_pkg::RST_STORM_THRESHOLD_LOW;
		end else if (i_reg_wr) begin
			if (hit_thr_high) begin
				thr_high_reg <= i_reg_wdata[storm_led_pkg::THR_HIGH_W-1:0];
			end
			if (hit_thr_low) begin
				thr_low_reg <= i_reg_wdata;
			end
		end
	end

	// factory bytes are storage only; nothing in the datapath reads them
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			factory_a_reg <= storm_led_pkg::RST_FACTORY_TEST_A;
			factory_b_reg <= storm_led_pkg::RST_FACTORY_TEST_B;
			factory_c_reg <= storm_led_pkg::RST_FACTORY_TEST_C;
		end else if (i_reg_wr) begin
			if (hit_fact_a) begin
				factory_a_reg <= i_reg_wdata;
			end
			if (hit_fact_b) begin
				factory_b_reg <= i_reg_wdata;
			end
			if (hit_fact_c) begin
				factory_c_reg <= i_reg_wdata;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ps_disable_reg <= storm_led_pkg::RST_POWER_SAVE_LED_LOW[storm_led_pkg::PS_DISABLE_BIT];
			factory_setting_reg <= storm_led_pkg::RST_POWER_SAVE_LED_LOW[storm_led_pkg::FACTORY_SETTING_BIT];
			ctrl_reserved_reg <= storm_led_pkg::RST_POWER_SAVE_LED_LOW[storm_led_pkg::CTRL_RESERVED_BIT];
		end else if (wr_ctrl) begin
			ps_disable_reg <= i_reg_wdata[storm_led_pkg::PS_DISABLE_BIT];
			factory_setting_reg <= i_reg_wdata[storm_led_pkg::FACTORY_SETTING_BIT];
			ctrl_reserved_reg <= i_reg_wdata[storm_led_pkg::CTRL_RESERVED_BIT];
		end
	end

	// the strap is a level, so it is caught by a clocked load after release, not by the reset itself
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			strap_state_reg <= storm_led_pkg::STRAP_PENDING;
			led_scheme_reg <= storm_led_pkg::LED_SCHEME_0;
		end else begin
			strap_state_reg <= storm_led_pkg::STRAP_DONE;
			led_scheme_reg <= led_scheme_next;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rdata_reg <= storm_led_pkg::READ_ZERO;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	genvar p;
	generate
		for (p = 0; p < storm_led_pkg::NUM_PORTS; p++) begin : g_port
			wire [2:0] code = led_code(led_scheme_reg, i_port_status[p]);

			storm_port_meter #(
				.WIN_FAST_CYCLES(WINDOW_FAST_CYCLES),
				.WIN_SLOW_CYCLES(WINDOW_SLOW_CYCLES)
			) u_meter (
				.i_core_clk(i_core_clk),
				.i_resetn(i_resetn),
				.i_enable(i_storm_enable[p]),
				.i_speed_100(i_port_status[p].speed_100),
				.i_block(i_bcast_block[p]),
				.i_threshold(threshold),
				.o_drop(o_bcast_drop[p]),
				.o_window_end(o_window_end[p]),
				.o_block_count()
			);

			// leds off during reset; registered so the pins never glitch
			always_ff @(posedge i_core_clk or negedge i_resetn) begin
				if (!i_resetn) begin
					ind_two_reg[p] <= storm_led_pkg::LED_OFF;
					ind_one_reg[p] <= storm_led_pkg::LED_OFF;
					ind_zero_reg[p] <= storm_led_pkg::LED_OFF;
				end else begin
					ind_two_reg[p] <= code[2];
					ind_one_reg[p] <= code[1];
					ind_zero_reg[p] <= code[0];
				end
			end
		end
	endgenerate
endmodule

// ===== verif/storm_led_sva.sv
/* port checker for the storm threshold and led global control bank.
   assumes port 0 stays at 100 Mbit/s, so its window is the fast one. */
`timescale 1ns/100ps
module storm_led_sva #(
	parameter int WINDOW_FAST_CYCLES = 20,
	parameter int WINDOW_SLOW_CYCLES = 200
) (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] o_reg_rdata,
	input wire logic i_led_scheme_strap_pin,
	input wire storm_led_pkg::port_status_s [4:0] i_port_status,
	input wire logic [4:0] i_storm_enable,
	input wire logic [4:0] i_bcast_block,
	input wire logic [4:0] o_bcast_drop,
	input wire logic [4:0] o_window_end,
	input wire logic o_phy_power_save_en,
	input wire logic [4:0] o_port_indicator_two,
	input wire logic [4:0] o_port_indicator_one,
	input wire logic [4:0] o_port_indicator_zero
);
	int gap_cnt;
	logic seen;
	// first window after reset is skipped: its start is not ours to see
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			gap_cnt <= 0;
			seen <= 1'b0;
		end else begin
			gap_cnt <= o_window_end[0] ? 0 : gap_cnt + 1;
			seen <= seen | o_window_end[0];
		end
	end
	default clocking @(posedge i_core_clk);
	endclocking
	default disable iff (!i_resetn);
	sequence ps_write;
		i_reg_wr && i_reg_addr == 8'h0B;
	endsequence
	read_slot_a:
		assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00) else $error("read data outside slot");
	unmapped_read_a:
		assert property (i_reg_rd && i_reg_addr > 8'h0B |=> o_reg_rdata == 8'h00) else $error("unmapped read");
	ps_write_a:
		assert property (ps_write |=> o_phy_power_save_en == !$past(i_reg_wdata[3])) else $error("power save");
	ps_hold_a:
		assert property ($changed(o_phy_power_save_en) |-> $past(i_reg_wr && i_reg_addr == 8'h0B)) else $error("ps moved");
	led_dark_a:
		assert property (i_resetn && !i_port_status[0].link_up |=> {o_port_indicator_two[0], o_port_indicator_one[0],
			o_port_indicator_zero[0]} == 3'h7) else $error("led lit on link down");
	led_full_a:
		// the release edge is skipped: the pins still hold their reset level one cycle later
		assert property (i_resetn && i_port_status[0].link_up && i_port_status[0].speed_100 && i_port_status[0].full_duplex
			|=> o_port_indicator_zero[0] == 1'b0) else $error("zero led dark");
	drop_gate_a:
		assert property (!i_storm_enable[1] |-> !o_bcast_drop[1]) else $error("drop while disabled");
	drop_cause_a:
		assert property ($rose(o_bcast_drop[0]) |-> $past(i_bcast_block[0]) || $past(i_reg_wr)) else $error("drop");
	window_len_a:
		assert property (o_window_end[0] && seen |-> gap_cnt == WINDOW_FAST_CYCLES - 1) else $error("window length");
endmodule
bind storm_rate_led_global_control storm_led_sva #(
	.WINDOW_FAST_CYCLES(WINDOW_FAST_CYCLES),
	.WINDOW_SLOW_CYCLES(WINDOW_SLOW_CYCLES)
) u_storm_led_sva (.*);

// ===== verif/test_storm_rate_led_global_control.sv
/* self-checking bench for the storm threshold and led global control bank.
   assumes windows shortened to 20 and 200 cycles. */
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_storm_rate_led_global_control;
	localparam int FAST = 20;
	localparam int SLOW = 200;
	localparam logic [7:0] RST_TAB [8] = '{8'h00, 8'h00, 8'h4A, 8'h24, 8'h28, 8'h24, 8'h00, 8'h00};
	logic i_core_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic [7:0] i_reg_addr = 8'h00;
	logic [7:0] i_reg_wdata = 8'h00;
	logic i_reg_wr = 1'b0;
	logic i_reg_rd = 1'b0;
	logic i_led_scheme_strap_pin = 1'b0;
	storm_led_pkg::port_status_s [4:0] i_port_status = {5{5'h1C}};
	logic [4:0] i_storm_enable = 5'h01;
	logic [4:0] i_bcast_block = 5'h00;
	logic [7:0] o_reg_rdata;
	logic [4:0] o_bcast_drop;
	logic [4:0] o_window_end;
	logic o_phy_power_save_en;
	logic [4:0] o_port_indicator_two;
	logic [4:0] o_port_indicator_one;
	logic [4:0] o_port_indicator_zero;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;
	int n;
	storm_rate_led_global_control #(.WINDOW_FAST_CYCLES(FAST), .WINDOW_SLOW_CYCLES(SLOW)) u_storm_rate_led_global_control (.*);
	always #4 i_core_clk = ~i_core_clk;
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// the full run needs under 1500 cycles
	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			end_of_test();
		end
	end
	task automatic do_reset(input logic s);
		@(posedge i_core_clk);
		i_resetn <= 1'b0;
		i_led_scheme_strap_pin <= s;
		repeat (10) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		repeat (2) @(posedge i_core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_core_clk);
		i_reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_core_clk);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_core_clk);
		i_reg_rd <= 1'b0;
		@(negedge i_core_clk);
		`CHK(o_reg_rdata, e)
	endtask
	// pins as {two, one, zero} per port, port 4 first
	task automatic led_chk(input logic [14:0] e);
		logic [14:0] g;
		@(posedge i_core_clk);
		@(negedge i_core_clk);
		for (int p = 0; p < 5; p++) g[3*p+:3] = {o_port_indicator_two[p], o_port_indicator_one[p], o_port_indicator_zero[p]};
		`CHK(g, e)
	endtask
	// bounded, so a missing pulse shows as a wrong n instead of a hang
	task automatic wait_win(input int p);
		n = 0;
		do begin
			@(negedge i_core_clk);
			n++;
		end while (!o_window_end[p] && n < 400);
	endtask
	initial begin
		do_reset(1'b0);
		for (int i = 0; i < 8; i++) rd(8'h05 + i[7:0], RST_TAB[i]);
		`CHK(o_phy_power_save_en, 1'b1)
		wr(8'h06, 8'hFF);
		rd(8'h06, 8'h07);
		for (int i = 0; i < 3; i++) begin
			wr(8'h08 + i[7:0], 8'hA5 - i[7:0]);
			rd(8'h08 + i[7:0], 8'hA5 - i[7:0]);
		end
		wr(8'h0C, 8'hFF);
		rd(8'h0C, 8'h00);
		wr(8'h0B, 8'hFF);
		rd(8'h0B, 8'h0F);
		`CHK(o_phy_power_save_en, 1'b0)
		@(posedge i_core_clk) i_port_status <= {5'h10, 5'h14, 5'h18, 5'h1C, 5'h0C};
		led_chk(15'h58D7);
		wr(8'h0B, 8'h00);
		@(posedge i_core_clk) i_port_status[0] <= 5'h1C;
		led_chk(15'h3280);
		@(posedge i_core_clk) i_port_status[2:1] <= {5'h19, 5'h1E};
		led_chk(15'h3220);
		wr(8'h06, 8'h00);
		wr(8'h07, 8'h03);
		wait_win(0);
		@(posedge i_core_clk) i_bcast_block <= 5'h1F;
		repeat (2) @(posedge i_core_clk);
		@(negedge i_core_clk);
		`CHK(o_bcast_drop, 5'h00)
		@(negedge i_core_clk);
		`CHK(o_bcast_drop, 5'h01)
		wait_win(0);
		@(negedge i_core_clk);
		`CHK(o_bcast_drop, 5'h00)
		wr(8'h06, 8'h01);
		wr(8'h07, 8'h00);
		wait_win(0);
		wait_win(0);
		`CHK(o_bcast_drop, 5'h00)
		@(posedge i_core_clk) i_bcast_block <= 5'h00;
		wait_win(1);
		wait_win(1);
		`CHK(n, FAST)
		wait_win(3);
		wait_win(3);
		`CHK(n, SLOW)
		do_reset(1'b1);
		rd(8'h0B, 8'h02);
		end_of_test();
	end
endmodule
